// [hw/wwd_pkg.sv]
// package: constants, state codes and carriers of the windowed watchdog
package wwd_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int APB_ADDR_W = 12;
    localparam logic [11:0] OFF_CONTROL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [6:0] COUNT_RESET = 7'h7f;
    localparam int ACT_BIT = 7;
    localparam int TOP_BIT = 6;
    localparam logic [6:0] COUNT_ROLL = 7'h40;

    // ************************************************************
    // prescaler and timing
    // ************************************************************
    localparam logic [13:0] PRE_MAX = 14'h3fff;
    localparam logic [14:0] WDG_DIV = 15'h4000;
    localparam logic [13:0] STEP_DIV64 = 14'h0040;
    localparam logic [13:0] WIN_BASE = 14'h0080;
    // per timebase_select: offset units added to the minimum window
    localparam logic [13:0] TB_LSB [0:3] = '{14'h003b, 14'h0035,
                                            14'h0023, 14'h0036};
    localparam int CLK_PERIOD_NS = 50;
    localparam int RESET_PULSE_NS = 30000;
    localparam logic [9:0] RESET_PULSE_CYC =
        10'(RESET_PULSE_NS / CLK_PERIOD_NS);
    localparam logic [12:0] STARTUP_SHORT = 13'h0100;
    localparam logic [12:0] STARTUP_LONG = 13'h1000;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [4:0] {
        ST_BOOT = 5'h01,
        ST_RUN = 5'h02,
        ST_HALT = 5'h04,
        ST_AHALT = 5'h08,
        ST_WAKE = 5'h10
    } wwd_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } wwd_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } wwd_apb_rsp_type;

    typedef struct packed {
        logic halt_exec;
        logic ext_irq;
        logic osc_irq;
        logic timebase_irq_enable;
        logic halt_reset_option;
        logic hw_watchdog_option;
        logic startup_long;
        logic [1:0] timebase_select;
    } wwd_sys_in_type;

    typedef struct packed {
        wwd_state_type state;
        logic [6:0] step_count;
        logic activation_bit;
        logic [13:0] pre;
        logic [13:0] first_wait;
        logic [12:0] start_cnt;
        logic [9:0] pulse_cnt;
        logic reset_n;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } wwd_regs_type;

    localparam wwd_regs_type REGS_RESET = '{
        state: ST_BOOT,
        step_count: COUNT_RESET,
        activation_bit: 1'b0,
        pre: 14'h0000,
        first_wait: 14'h0000,
        start_cnt: 13'h0000,
        pulse_cnt: 10'h000,
        reset_n: 1'b1,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0
    };

endpackage : wwd_pkg

// [hw/wwd_top.sv]
// module: windowed watchdog downcounter with APB control register
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps

module wwd_top
    import wwd_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic divided_osc_clock_in,
    input wire wwd_apb_req_type apb_req_in,
    input wire wwd_sys_in_type sys_in,
    output wwd_apb_rsp_type apb_rsp_out,
    output logic reset_pin_n_out
);

    // ************************************************************
    // state and decode
    // ************************************************************
    wwd_regs_type cur_reg;
    wwd_regs_type cur_next;

    logic active;
    logic running;
    logic wr_ctrl;
    logic setup;
    logic osc_tick;
    logic dec_tick;
    logic dec_now;
    logic reset_req;
    logic [13:0] win_min;
    logic [14:0] remain;

    // hardware option overrides the software activation bit
    // option forces active
    assign active = cur_reg.activation_bit | sys_in.hw_watchdog_option;
    assign running = (cur_reg.state == ST_RUN);
    assign osc_tick = divided_osc_clock_in;
    assign setup = apb_req_in.psel && !apb_req_in.penable && !cur_reg.pready;
    assign wr_ctrl = apb_req_in.psel && apb_req_in.penable &&
                     cur_reg.pready && apb_req_in.pwrite &&
                     (apb_req_in.paddr == OFF_CONTROL);
    assign win_min = 14'((TB_LSB[sys_in.timebase_select] + WIN_BASE) *
                         STEP_DIV64);
    assign remain = WDG_DIV - {1'b0, cur_reg.pre};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        cur_next = cur_reg;
        dec_tick = 1'b0;
        dec_now = 1'b0;
        reset_req = 1'b0;

        // prescaler is shared with the timebase, so it keeps running in
        // active halt; it freezes in full halt and during start-up
        // prescaler runs in run and active halt only
        if (osc_tick && (running || cur_reg.state == ST_AHALT)) begin
            cur_next.pre = cur_reg.pre + 14'h0001;
            if (cur_reg.first_wait != 14'h0000) begin
                cur_next.first_wait = cur_reg.first_wait - 14'h0001;
                if (cur_reg.first_wait == 14'h0001) begin
                    dec_tick = 1'b1;
                end
            end else if (cur_reg.pre == PRE_MAX) begin
                dec_tick = 1'b1;
            end
        end

        // counting goes on regardless of activation
        // free running count
        dec_now = dec_tick && running;
        if (dec_now) begin
            cur_next.step_count = cur_reg.step_count - 7'h01;
            if (active && cur_reg.step_count == COUNT_ROLL) begin
                reset_req = 1'b1;
            end
        end

        if (wr_ctrl) begin
            cur_next.step_count = apb_req_in.pwdata[6:0];
            cur_next.activation_bit = cur_reg.activation_bit |
                                      apb_req_in.pwdata[ACT_BIT];
            if ((cur_next.activation_bit || sys_in.hw_watchdog_option) &&
                !apb_req_in.pwdata[TOP_BIT]) begin
                reset_req = 1'b1;
            end
            // a write close to the prescaler wrap would give a too short
            // first step, so that step is pushed out to the window minimum
            // window minimum
            if (remain < {1'b0, win_min}) begin
                cur_next.first_wait = win_min;
            end else begin
                cur_next.first_wait = 14'h0000;
            end
        end

        // ********************************************************
        // low power modes
        // ********************************************************
        unique case (cur_reg.state)
            ST_BOOT: begin
                // oscillator start-up delay follows every reset
                // delay after reset
                cur_next.start_cnt = sys_in.startup_long ? STARTUP_LONG :
                                                           STARTUP_SHORT;
                cur_next.state = ST_WAKE;
            end
            ST_WAKE: begin
                if (cur_reg.start_cnt <= 13'h0001) begin
                    cur_next.state = ST_RUN;
                end else begin
                    cur_next.start_cnt = cur_reg.start_cnt - 13'h0001;
                end
            end
            ST_RUN: begin
                if (sys_in.halt_exec) begin
                    if (sys_in.timebase_irq_enable) begin
                        cur_next.state = ST_AHALT;
                    end else if (active && sys_in.halt_reset_option) begin
                        reset_req = 1'b1;
                    end else begin
                        // one last step, without a reset check
                        // decrement once
                        cur_next.step_count = cur_reg.step_count - 7'h01;
                        cur_next.state = ST_HALT;
                    end
                end
            end
            ST_HALT: begin
                if (sys_in.ext_irq) begin
                    cur_next.start_cnt = sys_in.startup_long ?
                                         STARTUP_LONG : STARTUP_SHORT;
                    cur_next.state = ST_WAKE;
                end
            end
            ST_AHALT: begin
                if (sys_in.osc_irq || sys_in.ext_irq) begin
                    cur_next.state = ST_RUN;
                end
            end
            default: begin
                cur_next.state = ST_BOOT;
            end
        endcase

        // ********************************************************
        // reset pin pulse
        // ********************************************************
        // the pin pulse is cut short if the system reset comes back first
        if (reset_req) begin
            cur_next.pulse_cnt = RESET_PULSE_CYC;
            cur_next.reset_n = 1'b0;
        end else if (cur_reg.pulse_cnt != 10'h000) begin
            cur_next.pulse_cnt = cur_reg.pulse_cnt - 10'h001;
            if (cur_reg.pulse_cnt == 10'h001) begin
                cur_next.reset_n = 1'b1;
            end
        end

        // ********************************************************
        // apb slave, no wait state; read data comes from a flop loaded in the setup phase
        // ********************************************************
        cur_next.pready = 1'b0;
        cur_next.pslverr = 1'b0;
        if (setup) begin
            cur_next.pready = 1'b1;
            if (apb_req_in.paddr == OFF_CONTROL) begin
                cur_next.prdata = {24'h00_0000, cur_reg.activation_bit,
                                   cur_reg.step_count};
            end else if (apb_req_in.paddr == OFF_STATUS) begin
                cur_next.prdata = {24'h00_0000, 1'b0, !cur_reg.reset_n,
                                   active, cur_reg.state};
            end else begin
                cur_next.prdata = 32'h0000_0000;
                cur_next.pslverr = 1'b1;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // reset clears activation
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cur_reg <= REGS_RESET;
        end else if (clk_en_in) begin
            cur_reg <= cur_next;
        end
    end

    assign apb_rsp_out = '{prdata: cur_reg.prdata,
                           pready: cur_reg.pready,
                           pslverr: cur_reg.pslverr};
    assign reset_pin_n_out = cur_reg.reset_n;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_roll;
        clk_en_in && dec_now && active && cur_reg.step_count == COUNT_ROLL;
    endsequence

    sequence s_pin_low2;
        !reset_pin_n_out ##1 !reset_pin_n_out;
    endsequence

    sequence s_sw_reset;
        clk_en_in && wr_ctrl && !apb_req_in.pwdata[TOP_BIT] &&
        (apb_req_in.pwdata[ACT_BIT] || active);
    endsequence

    property p_step_on_wrap;
        dec_now && cur_reg.first_wait == 14'h0000 |->
            cur_reg.pre == PRE_MAX;
    endproperty
    a_step_on_wrap: assert property (p_step_on_wrap)
        else $error("step without prescaler wrap");

    property p_load_low;
        clk_en_in && wr_ctrl |=>
            cur_reg.step_count[5:0] == $past(apb_req_in.pwdata[5:0]);
    endproperty
    a_load_low: assert property (p_load_low)
        else $error("timeout bits not loaded");

    property p_roll_reset;
        s_roll |=> s_pin_low2;
    endproperty
    a_roll_reset: assert property (p_roll_reset)
        else $error("rollover gave no reset pulse");

    property p_free_run;
        clk_en_in && dec_now && !active && !wr_ctrl |=>
            cur_reg.step_count == $past(cur_reg.step_count) - 7'h01;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("inactive counter did not step");

    property p_pre_kept;
        clk_en_in && wr_ctrl && running && osc_tick |=>
            cur_reg.pre == $past(cur_reg.pre) + 14'h0001;
    endproperty
    a_pre_kept: assert property (p_pre_kept)
        else $error("prescaler disturbed by write");

    property p_sticky;
        cur_reg.activation_bit |=> cur_reg.activation_bit;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("activation bit cleared");

    property p_sw_reset;
        s_sw_reset |=> s_pin_low2;
    endproperty
    a_sw_reset: assert property (p_sw_reset)
        else $error("software reset missing");

    property p_halt_reset;
        clk_en_in && running && sys_in.halt_exec && active &&
        !sys_in.timebase_irq_enable && sys_in.halt_reset_option |=>
            !reset_pin_n_out && cur_reg.state == ST_RUN;
    endproperty
    a_halt_reset: assert property (p_halt_reset)
        else $error("halt reset missing");

    property p_halt_frozen;
        cur_reg.state == ST_HALT && !wr_ctrl |=> $stable(cur_reg.step_count);
    endproperty
    a_halt_frozen: assert property (p_halt_frozen)
        else $error("count moved in halt");

    property p_ext_wake;
        clk_en_in && cur_reg.state == ST_HALT && sys_in.ext_irq |=>
            cur_reg.state == ST_WAKE && cur_reg.start_cnt >= STARTUP_SHORT;
    endproperty
    a_ext_wake: assert property (p_ext_wake)
        else $error("halt wake without delay");

    property p_ahalt_resume;
        clk_en_in && cur_reg.state == ST_AHALT &&
        (sys_in.osc_irq || sys_in.ext_irq) |=> cur_reg.state == ST_RUN;
    endproperty
    a_ahalt_resume: assert property (p_ahalt_resume)
        else $error("active halt did not resume");

    property p_window;
        clk_en_in && wr_ctrl && remain < {1'b0, win_min} |=>
            cur_reg.first_wait == $past(win_min);
    endproperty
    a_window: assert property (p_window)
        else $error("first step window not armed");

    property p_hw_option;
        clk_en_in && dec_now && sys_in.hw_watchdog_option &&
        cur_reg.step_count == COUNT_ROLL |=> !reset_pin_n_out;
    endproperty
    a_hw_option: assert property (p_hw_option)
        else $error("hardware option rollover missed");

    property p_reset_inactive;
        disable iff (1'b0) rst_in |=> !cur_reg.activation_bit;
    endproperty
    a_reset_inactive: assert property (p_reset_inactive)
        else $error("active after reset");

    property p_pulse_end;
        clk_en_in && !reset_req && cur_reg.pulse_cnt == 10'h001 |=>
            reset_pin_n_out;
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("reset pulse did not end");

    // plain halt: exactly one last step on entry, then halted
    property p_halt_entry;
        clk_en_in && running && sys_in.halt_exec &&
        !sys_in.timebase_irq_enable &&
        !(active && sys_in.halt_reset_option) && !wr_ctrl |=>
            cur_reg.state == ST_HALT &&
            cur_reg.step_count == $past(cur_reg.step_count) - 7'h01;
    endproperty
    a_halt_entry: assert property (p_halt_entry)
        else $error("halt entry did not step once");

    property p_ahalt_frozen;
        cur_reg.state == ST_AHALT && !wr_ctrl |=>
            $stable(cur_reg.step_count);
    endproperty
    a_ahalt_frozen: assert property (p_ahalt_frozen)
        else $error("count moved in active halt");

    property p_wake_hold;
        clk_en_in && cur_reg.state == ST_WAKE &&
        cur_reg.start_cnt > 13'h0001 |=> cur_reg.state == ST_WAKE;
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("start-up delay cut short");

endmodule : wwd_top

// [verif/wwd_top_tb.sv]
// testbench: register-level tests of the windowed watchdog downcounter
`timescale 1ns/100ps

module wwd_top_tb;
    import wwd_pkg::*;

    // ************************************************************
    // clock, stimulus and counters
    // ************************************************************
    localparam int WIN_MIN = (59 + 128) * 64;
    localparam int PULSE = int'(RESET_PULSE_CYC);
    localparam int LIMIT = 80000;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    wwd_apb_req_type req = '0;
    wwd_sys_in_type sys = '0;
    wwd_apb_rsp_type apb_rsp_out;
    logic reset_pin_n_out;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int waited;
    int len;

    always #25 sys_clk_in = ~sys_clk_in;

    // prescaler tick and clock enable held high: full-rate counting
    wwd_top dut (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .clk_en_in(1'b1),
        .divided_osc_clock_in(1'b1),
        .apb_req_in(req),
        .sys_in(sys),
        .apb_rsp_out(apb_rsp_out),
        .reset_pin_n_out(reset_pin_n_out)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count = fail_count + 1;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge sys_clk_in);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= addr;
        req.pwdata <= wd;
        @(posedge sys_clk_in);
        req.penable <= 1'b1;
        // access held until pready is sampled high at a rising edge;
        // data and error are taken at that same edge, only the bench
        // timeout ends a wait that never finishes
        do begin
            @(posedge sys_clk_in);
        end while (apb_rsp_out.pready !== 1'b1);
        rd = apb_rsp_out.prdata;
        err = apb_rsp_out.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [11:0] addr, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, {24'h000000, d}, rd, err);
        check({31'h0, err}, 32'h0);
    endtask : wr_reg

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 32'h0, rd, err);
        check(rd, exp);
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : idle

    task automatic do_reset(input logic long_start);
        sys.startup_long <= long_start;
        rst_in <= 1'b1;
        idle(2);
        rst_in <= 1'b0;
    endtask : do_reset

    task automatic sys_pulse(input int which);
        @(posedge sys_clk_in);
        if (which == 0) sys.halt_exec <= 1'b1;
        if (which == 1) sys.ext_irq <= 1'b1;
        if (which == 2) sys.osc_irq <= 1'b1;
        @(posedge sys_clk_in);
        sys.halt_exec <= 1'b0;
        sys.ext_irq <= 1'b0;
        sys.osc_irq <= 1'b0;
    endtask : sys_pulse

    // waits for the pin to fall, then counts the cycles it stays low
    task automatic pulse_len(input int maxw);
        waited = 0;
        len = 0;
        while (reset_pin_n_out !== 1'b0 && waited < maxw) begin
            @(negedge sys_clk_in);
            waited = waited + 1;
        end
        while (reset_pin_n_out === 1'b0 && len < PULSE + 50) begin
            @(negedge sys_clk_in);
            len = len + 1;
        end
        // later stimulus is launched from a rising edge again
        @(posedge sys_clk_in);
    endtask : pulse_len

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [31:0] rd;
        logic err;
        do_reset(1'b0);
        idle(300);
        rd_chk(OFF_CONTROL, 32'h7f);
        rd_chk(OFF_STATUS, 32'h02);
        apb(1'b0, 12'h008, 32'h0, rd, err);
        check({31'h0, err}, 32'h1);
        wr_reg(OFF_STATUS, 8'hff);
        rd_chk(OFF_STATUS, 32'h02);
        idle(15600);
        rd_chk(OFF_CONTROL, 32'h7f);
        idle(5500);
        rd_chk(OFF_CONTROL, 32'h7e);
        wr_reg(OFF_CONTROL, 8'h45);
        rd_chk(OFF_CONTROL, 32'h45);
        // prescaler phase kept: first step at the window minimum
        wr_reg(OFF_CONTROL, 8'hc0);
        wr_reg(OFF_CONTROL, 8'h40);
        rd_chk(OFF_CONTROL, 32'hc0);
        pulse_len(17000);
        check(32'(waited >= WIN_MIN - 20 && waited <= WIN_MIN), 32'h1);
        check(32'(len), 32'(PULSE));
        do_reset(1'b0);
        idle(300);
        rd_chk(OFF_CONTROL, 32'h7f);
        wr_reg(OFF_CONTROL, 8'hbf);
        pulse_len(4);
        check(32'(waited <= 2), 32'h1);
        check(32'(len), 32'(PULSE));
        do_reset(1'b0);
        idle(300);
        wr_reg(OFF_CONTROL, 8'hff);
        sys.timebase_irq_enable <= 1'b1;
        sys_pulse(0);
        rd_chk(OFF_STATUS, 32'h28);
        idle(17000);
        rd_chk(OFF_CONTROL, 32'hff);
        sys_pulse(2);
        rd_chk(OFF_STATUS, 32'h22);
        sys.timebase_irq_enable <= 1'b0;
        sys.halt_reset_option <= 1'b1;
        sys_pulse(0);
        pulse_len(4);
        check(32'(waited <= 2), 32'h1);
        sys.halt_reset_option <= 1'b0;
        sys.hw_watchdog_option <= 1'b1;
        do_reset(1'b0);
        idle(300);
        rd_chk(OFF_STATUS, 32'h22);
        wr_reg(OFF_CONTROL, 8'h3f);
        pulse_len(4);
        check(32'(waited <= 2), 32'h1);
        sys.hw_watchdog_option <= 1'b0;
        // plain halt: one step then frozen
        do_reset(1'b0);
        idle(300);
        wr_reg(OFF_CONTROL, 8'hff);
        sys_pulse(0);
        rd_chk(OFF_CONTROL, 32'hfe);
        rd_chk(OFF_STATUS, 32'h24);
        idle(17000);
        rd_chk(OFF_CONTROL, 32'hfe);
        check({31'h0, reset_pin_n_out}, 32'h1);
        sys_pulse(1);
        idle(200);
        rd_chk(OFF_STATUS, 32'h30);
        idle(60);
        rd_chk(OFF_STATUS, 32'h22);
        sys_pulse(0);
        do_reset(1'b1);
        idle(4000);
        rd_chk(OFF_STATUS, 32'h10);
        idle(200);
        rd_chk(OFF_STATUS, 32'h02);
        rd_chk(OFF_CONTROL, 32'h7f);
        tally_and_finish();
    end

endmodule : wwd_top_tb
